/* rtl/pfp_pkg.sv */
// shared constants of the parallel programming fuse port
package pfp_pkg;
   // ----------------------------------------------------------------
   // command encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_NOP      = 8'h00;
   localparam logic [7:0] CMD_ERASE    = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE    = 8'h11;
   localparam logic [7:0] CMD_RD_SIG   = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EE    = 8'h03;
   // ----------------------------------------------------------------
   // action select codes on a crystal strobe edge
   // ----------------------------------------------------------------
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;
   // ----------------------------------------------------------------
   // fuse defaults (0 = programmed) and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] FUSE_EXT_RST  = 8'hFD;
   localparam logic [7:0] FUSE_HI_RST   = 8'h99;
   localparam logic [7:0] FUSE_LO_RST   = 8'hE1;
   localparam logic [7:0] LOCK_RST      = 8'hFF;
   localparam logic [5:0] EXT_UNUSED    = 6'h3F;
   localparam int         EXT_WDT_BIT   = 0;
   localparam int         EXT_LEGACY_BIT = 1;
   localparam int         HI_SERIAL_PROG_ENABLE_FUSE_BIT  = 5;
   localparam int         HI_EEPROM_PRESERVE_FUSE_BIT = 3;
   localparam int         LOCK_LB1_BIT  = 0;
   // ----------------------------------------------------------------
   // paging
   // ----------------------------------------------------------------
   localparam int FLASH_WORD_BITS = 7;
   localparam int FLASH_PAGE_BITS = 9;
   localparam int EE_BYTE_BITS    = 3;
   localparam int EE_PAGE_BITS    = 9;
   localparam int ADDR_BITS       = 16;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FUSE_WR_NS    = 1000;
   localparam int FUSE_WR_CYC   = (FUSE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // nonvolatile operation codes toward the memory arrays
   // ----------------------------------------------------------------
   localparam logic [1:0] NVM_ERASE = 2'h0;
   localparam logic [1:0] NVM_FLASH = 2'h1;
   localparam logic [1:0] NVM_EE    = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_NVM  = 3'b010,
      ST_FUSE = 3'b100
   } pfp_state_t;
endpackage : pfp_pkg

/* rtl/pfp_port.sv */
// parallel programming port with fuse, lock, signature and calibration storage
`timescale 1ns/1ps
`default_nettype none
module pfp_port #(
   parameter logic [7:0] SIG_BYTE0 = 8'h5A, // arbitrary identification value
   parameter logic [7:0] SIG_BYTE1 = 8'hA5, // arbitrary identification value
   parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary identification value
   parameter logic [7:0] CAL_1MHZ  = 8'h80, // calibration for 1 MHz
   parameter logic [7:0] CAL_2MHZ  = 8'h81, // calibration for 2 MHz
   parameter logic [7:0] CAL_4MHZ  = 8'h82, // calibration for 4 MHz
   parameter logic [7:0] CAL_8MHZ  = 8'h83  // calibration for 8 MHz
) (
   input  wire logic        i_clk,           // core clock, 100 MHz
   input  wire logic        i_rst_n,         // async reset, active low
   input  wire logic        i_xtal_clk,      // crystal input strobe, link clock
   input  wire logic        i_prog_mode,     // high voltage entry detected (pin)
   input  wire logic        i_serial_mode,   // serial programming mode active (pin)
   input  wire logic        i_action_select_lo, // action select bit 0 (pin)
   input  wire logic        i_action_select_hi, // action select bit 1 (pin)
   input  wire logic        i_byte_select_first,  // first byte select (pin)
   input  wire logic        i_byte_select_second, // second byte select (pin)
   input  wire logic        i_page_load_strobe,   // page load strobe (pin)
   input  wire logic        i_wr_n,          // write pulse, active low (pin)
   input  wire logic        i_oe_n,          // output enable, active low (pin)
   input  wire logic [7:0]  i_data,          // data bus input
   output logic      [7:0]  o_data,          // data bus output
   output logic             o_data_oe,       // data bus drive enable
   output logic             o_ready_busy_out,// 1 ready, 0 busy
   output logic             o_nvm_start,     // one-cycle start of array operation
   output logic      [1:0]  o_nvm_op,        // array operation code
   output logic      [8:0]  o_nvm_page,      // page index of the operation
   input  wire logic        i_nvm_done,      // array operation finished, pulse
   input  wire logic [15:0] i_nvm_rdata,     // array read data at o_nvm_addr
   output logic      [15:0] o_nvm_addr,      // loaded address
   output logic             o_pbuf_we,       // one-cycle page buffer write
   output logic      [6:0]  o_pbuf_idx,      // word or byte index in the page
   output logic      [15:0] o_pbuf_wdata,    // page buffer data
   output logic      [7:0]  o_fuse_ext,      // latched extended fuse byte
   output logic      [7:0]  o_fuse_hi,       // latched high fuse byte
   output logic      [7:0]  o_fuse_lo,       // latched low fuse byte
   output logic      [7:0]  o_lock_bits,     // lock byte
   output logic             o_eeprom_preserve, // effective preserve, 0 = preserve
   output logic      [7:0]  o_osc_calibration_reg // oscillator calibration
);
   // ----------------------------------------------------------------
   // link domain: loads on the crystal strobe
   // ----------------------------------------------------------------
   logic [7:0]  l_cmd_q;
   logic [15:0] l_addr_q;
   logic [7:0]  l_dlo_q;
   logic [7:0]  l_dhi_q;
   logic        l_tgl_q;

   always_ff @(posedge i_xtal_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         l_cmd_q  <= pfp_pkg::CMD_NOP;
         l_addr_q <= 16'h0000;
         l_dlo_q  <= 8'hFF;
         l_dhi_q  <= 8'hFF;
         l_tgl_q  <= 1'b0;
      end else if ({i_action_select_hi, i_action_select_lo} != 2'h3) begin
         unique case ({i_action_select_hi, i_action_select_lo})
            pfp_pkg::ACT_ADDR: begin
               if (i_byte_select_first) l_addr_q[15:8] <= i_data;
               else l_addr_q[7:0] <= i_data;
            end
            pfp_pkg::ACT_DATA: begin
               if (i_byte_select_first) l_dhi_q <= i_data;
               else l_dlo_q <= i_data;
            end
            default: l_cmd_q <= i_data;
         endcase
         l_tgl_q <= ~l_tgl_q;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers into the core domain
   // ----------------------------------------------------------------
   logic [7:0] sync_q;
   logic       wr_n_s, oe_n_s, page_load_strobe_s, bs1_s, bs2_s, prog_s, ser_s, tgl_s;

   // reset to idle pin levels so no false edge or mode follows reset
   pfp_sync2 #(.WIDTH(8), .RST_VAL(8'hC0)) u_sync (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_d       ({i_wr_n, i_oe_n, i_page_load_strobe, i_byte_select_first,
                   i_byte_select_second, i_prog_mode, i_serial_mode, l_tgl_q}),
      .o_q       (sync_q)
   );
   assign {wr_n_s, oe_n_s, page_load_strobe_s, bs1_s, bs2_s, prog_s, ser_s, tgl_s} = sync_q;

   logic wr_n_d1_q, page_load_strobe_d1_q, prog_d1_q, tgl_d1_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_n_d1_q  <= 1'b1;
         page_load_strobe_d1_q <= 1'b0;
         prog_d1_q  <= 1'b0;
         tgl_d1_q   <= 1'b0;
      end else begin
         wr_n_d1_q  <= wr_n_s;
         page_load_strobe_d1_q <= page_load_strobe_s;
         prog_d1_q  <= prog_s;
         tgl_d1_q   <= tgl_s;
      end
   end

   logic wr_fall, page_load_strobe_rise, prog_rise, load_ev, in_prog;
   assign in_prog    = prog_s && prog_d1_q;
   assign wr_fall    = in_prog && wr_n_d1_q && !wr_n_s;
   assign page_load_strobe_rise = in_prog && !page_load_strobe_d1_q && page_load_strobe_s;
   assign prog_rise  = prog_s && !prog_d1_q;
   assign load_ev    = tgl_s != tgl_d1_q;

   // ----------------------------------------------------------------
   // core copies of command, address and data
   // ----------------------------------------------------------------
   logic [7:0]  cmd_q;
   logic [15:0] addr_q;
   logic [7:0]  dlo_q, dhi_q;
   logic        pg_en_q;

   // link registers are still: the strobe stands until the next pulse
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_q   <= pfp_pkg::CMD_NOP;
         addr_q  <= 16'h0000;
         dlo_q   <= 8'hFF;
         dhi_q   <= 8'hFF;
         pg_en_q <= 1'b0;
      end else if (load_ev) begin
         cmd_q   <= l_cmd_q;
         addr_q  <= l_addr_q;
         dlo_q   <= l_dlo_q;
         dhi_q   <= l_dhi_q;
         pg_en_q <= (l_cmd_q == pfp_pkg::CMD_WR_FLASH) || (l_cmd_q == pfp_pkg::CMD_WR_EE);
      end
   end

   function automatic logic is_ee(input logic [7:0] c);
      return (c == pfp_pkg::CMD_WR_EE) || (c == pfp_pkg::CMD_RD_EE);
   endfunction : is_ee

   function automatic logic [8:0] page_of(input logic [7:0] c, input logic [15:0] a);
      return is_ee(c) ? a[11:3] : a[15:7];
   endfunction : page_of

   // ----------------------------------------------------------------
   // fuse and lock storage
   // ----------------------------------------------------------------
   logic [7:0] fuse_ext_q, fuse_hi_q, fuse_lo_q, lock_q;
   logic       fuse_wr, lock_wr, erase_go, nvm_go;
   logic [7:0] hi_wdata;
   pfp_pkg::pfp_state_t state_q;

   assign fuse_wr  = wr_fall && state_q == pfp_pkg::ST_IDLE && cmd_q == pfp_pkg::CMD_WR_FUSE
                     && lock_q[pfp_pkg::LOCK_LB1_BIT];
   assign lock_wr  = wr_fall && state_q == pfp_pkg::ST_IDLE && cmd_q == pfp_pkg::CMD_WR_LOCK;
   assign erase_go = wr_fall && state_q == pfp_pkg::ST_IDLE && cmd_q == pfp_pkg::CMD_ERASE;
   assign nvm_go   = erase_go || (wr_fall && state_q == pfp_pkg::ST_IDLE && pg_en_q &&
                     (cmd_q == pfp_pkg::CMD_WR_FLASH || cmd_q == pfp_pkg::CMD_WR_EE));

   always_comb begin
      hi_wdata = dlo_q;
      if (ser_s) begin
         hi_wdata[pfp_pkg::HI_SERIAL_PROG_ENABLE_FUSE_BIT] = fuse_hi_q[pfp_pkg::HI_SERIAL_PROG_ENABLE_FUSE_BIT];
      end
   end

   // erase does not touch this process; fuses change only on a fuse write
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fuse_ext_q <= pfp_pkg::FUSE_EXT_RST;
         fuse_hi_q  <= pfp_pkg::FUSE_HI_RST;
         fuse_lo_q  <= pfp_pkg::FUSE_LO_RST;
      end else if (fuse_wr) begin
         unique case ({bs1_s, bs2_s})
            2'b10:   fuse_hi_q  <= hi_wdata;
            2'b01:   fuse_ext_q <= {pfp_pkg::EXT_UNUSED, dlo_q[1:0]};
            default: fuse_lo_q  <= dlo_q;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_q <= pfp_pkg::LOCK_RST;
      end else if (erase_go) begin
         lock_q <= pfp_pkg::LOCK_RST;
      end else if (lock_wr) begin
         lock_q <= lock_q & dlo_q;
      end
   end

   // ----------------------------------------------------------------
   // working latches of the fuses
   // ----------------------------------------------------------------
   logic [7:0] act_ext_q, act_hi_q, act_lo_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         act_ext_q <= pfp_pkg::FUSE_EXT_RST;
         act_hi_q  <= pfp_pkg::FUSE_HI_RST;
         act_lo_q  <= pfp_pkg::FUSE_LO_RST;
      end else if (prog_rise || !prog_s) begin
         act_ext_q <= fuse_ext_q;
         act_hi_q  <= fuse_hi_q;
         act_lo_q  <= fuse_lo_q;
      end
   end
   assign o_fuse_ext  = act_ext_q;
   assign o_fuse_hi   = act_hi_q;
   assign o_fuse_lo   = act_lo_q;
   assign o_lock_bits = lock_q;
   assign o_eeprom_preserve = act_hi_q[pfp_pkg::HI_EEPROM_PRESERVE_FUSE_BIT]
                              & fuse_hi_q[pfp_pkg::HI_EEPROM_PRESERVE_FUSE_BIT];

   // ----------------------------------------------------------------
   // operation sequencer and ready/busy
   // ----------------------------------------------------------------
   localparam int TW = $clog2(pfp_pkg::FUSE_WR_CYC + 1);
   logic [TW-1:0] tmr_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= pfp_pkg::ST_IDLE;
         tmr_q   <= '0;
      end else begin
         unique case (state_q)
            pfp_pkg::ST_IDLE: begin
               if (nvm_go) begin
                  state_q <= pfp_pkg::ST_NVM;
               end else if (fuse_wr || lock_wr) begin
                  state_q <= pfp_pkg::ST_FUSE;
                  tmr_q   <= TW'(pfp_pkg::FUSE_WR_CYC - 1);
               end
            end
            pfp_pkg::ST_NVM: begin
               if (i_nvm_done) state_q <= pfp_pkg::ST_IDLE;
            end
            pfp_pkg::ST_FUSE: begin
               if (tmr_q == '0) state_q <= pfp_pkg::ST_IDLE;
               else tmr_q <= tmr_q - TW'(1);
            end
            default: state_q <= pfp_pkg::ST_IDLE;
         endcase
      end
   end
   assign o_ready_busy_out = state_q == pfp_pkg::ST_IDLE;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_nvm_start <= 1'b0;
         o_nvm_op    <= pfp_pkg::NVM_ERASE;
         o_nvm_page  <= 9'h000;
      end else begin
         o_nvm_start <= nvm_go;
         if (nvm_go) begin
            o_nvm_op   <= erase_go ? pfp_pkg::NVM_ERASE :
                          is_ee(cmd_q) ? pfp_pkg::NVM_EE : pfp_pkg::NVM_FLASH;
            o_nvm_page <= page_of(cmd_q, addr_q);
         end
      end
   end
   assign o_nvm_addr = addr_q;

   // ----------------------------------------------------------------
   // page buffer loads
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pbuf_we    <= 1'b0;
         o_pbuf_idx   <= 7'h00;
         o_pbuf_wdata <= 16'hFFFF;
      end else begin
         o_pbuf_we <= page_load_strobe_rise && pg_en_q;
         if (page_load_strobe_rise && pg_en_q) begin
            o_pbuf_idx   <= is_ee(cmd_q) ? {4'h0, addr_q[2:0]} : addr_q[6:0];
            o_pbuf_wdata <= is_ee(cmd_q) ? {8'hFF, dlo_q} : {dhi_q, dlo_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // read path and bus drive
   // ----------------------------------------------------------------
   logic [7:0] rd_d;
   logic [7:0] sig_rd, cal_rd, hi_rd;

   always_comb begin
      hi_rd = fuse_hi_q;
      if (ser_s) hi_rd[pfp_pkg::HI_SERIAL_PROG_ENABLE_FUSE_BIT] = 1'b1;
      unique case (addr_q[1:0])
         2'h0:    sig_rd = SIG_BYTE0;
         2'h1:    sig_rd = SIG_BYTE1;
         2'h2:    sig_rd = SIG_BYTE2;
         default: sig_rd = 8'hFF;
      endcase
      unique case (addr_q[1:0])
         2'h0:    cal_rd = CAL_1MHZ;
         2'h1:    cal_rd = CAL_2MHZ;
         2'h2:    cal_rd = CAL_4MHZ;
         default: cal_rd = CAL_8MHZ;
      endcase
      rd_d = 8'hFF;
      unique case (cmd_q)
         pfp_pkg::CMD_RD_SIG:   rd_d = bs1_s ? cal_rd : sig_rd;
         pfp_pkg::CMD_RD_FUSE: begin
            unique case ({bs1_s, bs2_s})
               2'b00:   rd_d = fuse_lo_q;
               2'b11:   rd_d = hi_rd;
               2'b01:   rd_d = fuse_ext_q;
               default: rd_d = lock_q;
            endcase
         end
         pfp_pkg::CMD_RD_FLASH: rd_d = bs1_s ? i_nvm_rdata[15:8] : i_nvm_rdata[7:0];
         pfp_pkg::CMD_RD_EE:    rd_d = i_nvm_rdata[7:0];
         default:               rd_d = 8'hFF;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data <= 8'hFF;
      end else begin
         o_data <= rd_d;
      end
   end
   assign o_data_oe = in_prog && !oe_n_s;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_osc_calibration_reg <= CAL_1MHZ;
      end else begin
         o_osc_calibration_reg <= o_osc_calibration_reg;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_busy_while_op: assert property (o_nvm_start |-> !o_ready_busy_out)
      else $error("ready shown during an operation");
   a_fuse_time: assert property ((fuse_wr || lock_wr) |=> !o_ready_busy_out [*8])
      else $error("fuse write busy too short");
   a_fuse_locked: assert property (wr_fall && cmd_q == pfp_pkg::CMD_WR_FUSE
      && !lock_q[pfp_pkg::LOCK_LB1_BIT] |=> $stable({fuse_ext_q, fuse_hi_q, fuse_lo_q}))
      else $error("fuse written while locked");
   a_erase_fuses: assert property (erase_go |=> $stable({fuse_ext_q, fuse_hi_q, fuse_lo_q})
      && lock_q == pfp_pkg::LOCK_RST)
      else $error("erase changed fuses or left locks");
   a_bus_drive: assert property (o_data_oe |-> !$past(i_oe_n, 2) &&
      $past(i_prog_mode, 2) && $past(i_prog_mode, 3))
      else $error("bus driven without output enable");
   a_ext_unused: assert property (fuse_ext_q[7:2] == pfp_pkg::EXT_UNUSED)
      else $error("unused extended bits not one");
   a_latch_hold: assert property (in_prog && $past(in_prog) |-> $stable(act_lo_q))
      else $error("fuse latch moved in programming mode");
   a_preserve_now: assert property (fuse_wr && bs1_s && !bs2_s &&
      !hi_wdata[pfp_pkg::HI_EEPROM_PRESERVE_FUSE_BIT] |=> !o_eeprom_preserve)
      else $error("preserve fuse not immediate");
   a_bad_cmd: assert property (wr_fall && o_ready_busy_out && !pg_en_q
      && cmd_q != pfp_pkg::CMD_ERASE
      && cmd_q != pfp_pkg::CMD_WR_FUSE && cmd_q != pfp_pkg::CMD_WR_LOCK
      |=> o_ready_busy_out && !o_nvm_start)
      else $error("unknown command started work");
   a_nop_ends: assert property (load_ev && l_cmd_q == pfp_pkg::CMD_NOP |=> !pg_en_q)
      else $error("no-op left page write enabled");
   a_serial_serial_prog_enable_fuse: assert property (ser_s && fuse_wr |=>
      $stable(fuse_hi_q[pfp_pkg::HI_SERIAL_PROG_ENABLE_FUSE_BIT]))
      else $error("serial enable fuse written in serial mode");

   c_flash_page: cover property (o_pbuf_we ##[1:200] o_nvm_start && o_nvm_op == pfp_pkg::NVM_FLASH);
   c_fuse_write: cover property (fuse_wr ##[1:200] o_ready_busy_out);
   c_erase: cover property (erase_go ##[1:200] i_nvm_done);
   c_read_sig: cover property (o_data_oe && cmd_q == pfp_pkg::CMD_RD_SIG);
endmodule : pfp_port
`default_nettype wire

/* rtl/pfp_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pfp_sync2 #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0  // idle level of each input
) (
   input  wire logic             i_clk,    // destination clock
   input  wire logic             i_rst_n,  // async reset, active low
   input  wire logic [WIDTH-1:0] i_d,      // asynchronous input
   output logic      [WIDTH-1:0] o_q       // synchronised output
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end

endmodule : pfp_sync2
`default_nettype wire

/* test/pfp_port_tb_top.sv */
// self-checking bench of the parallel programming port
`timescale 1ns/1ps
`default_nettype none
module pfp_port_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, prog = 1'b0, bs2 = 1'b0, wr_n = 1'b1, oe_n = 1'b1;
   logic smp = 1'b0, xtal, bs1, rdy, doe, st;
   logic ser = 1'b0, pl = 1'b0, pwe, ep;
   logic [1:0] nvo;
   logic [8:0] npg;
   logic [6:0] pix;
   logic [15:0] nrd = 16'h0000, na, pwd, a, d;
   logic [31:0] ev[$];
   logic [1:0] act;
   logic [7:0] pd, dq, fx, fh, fl, lk, cal, v;
   logic [2:0] sel = 3'h0;
   logic [31:0] dly = 32'h0000_0000;
   logic [7:0] q[$];
   int fails = 0, checks = 0;
   localparam logic [63:0] SC = 64'h5AA5_3CFF_8081_8283;
   wire logic [63:0] ob = {{7'h00, ep}, doe ? dq : 8'hxx, {7'h00, rdy}, lk, cal, fx, fh, fl};
   always #5 clk = ~clk;
   // array model: done comes 32 cycles after start
   always @(posedge clk) dly <= {dly[30:0], st};
   pfp_port uut (.i_clk(clk), .i_rst_n(rst_n), .i_xtal_clk(xtal), .i_prog_mode(prog),
      .i_serial_mode(ser), .i_action_select_lo(act[0]), .i_action_select_hi(act[1]),
      .i_byte_select_first(bs1), .i_byte_select_second(bs2), .i_page_load_strobe(pl),
      .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(pd), .o_data(dq), .o_data_oe(doe),
      .o_ready_busy_out(rdy), .o_nvm_start(st), .o_nvm_op(nvo), .o_nvm_page(npg),
      .i_nvm_done(dly[31]), .i_nvm_rdata(nrd), .o_nvm_addr(na), .o_pbuf_we(pwe),
      .o_pbuf_idx(pix), .o_pbuf_wdata(pwd), .o_fuse_ext(fx), .o_fuse_hi(fh), .o_fuse_lo(fl),
      .o_lock_bits(lk), .o_eeprom_preserve(ep), .o_osc_calibration_reg(cal));
   pfp_prog_model prog_m (.o_xtal(xtal), .o_act(act), .o_bs1(bs1), .o_data(pd));
   task automatic summarize();
      // a note never met by its result counts as a mismatch
      if (q.size() != 0 || ev.size() != 0) begin
         fails++;
      end
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t event %h want %h", $time, got, exp);
      end
   endtask : cmp32
   task automatic pgl();
      pl <= 1'b1;
      repeat (25) @(posedge clk);
      pl <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pgl
   task automatic chk(input logic [2:0] s, input logic [7:0] e);
      q.push_back(e);
      sel <= s;
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
      @(posedge clk);
   endtask : chk
   task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
      prog_m.load(a, b, d);
      repeat (6) @(posedge clk);
   endtask : ld
   task automatic wr(input logic [7:0] e);
      wr_n <= 1'b0;
      repeat (25) @(posedge clk);
      chk(3'h5, e);
      wr_n <= 1'b1;
      for (int i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : wr
   // watcher: oldest note against the selected output
   always @(posedge clk) begin
      if (smp) begin
         cmp8(ob[sel*8 +: 8], q.pop_front());
      end
      if (pwe) begin
         cmp32({1'b1, 8'h00, pix, pwd}, ev.pop_front());
      end
      if (st) begin
         cmp32({1'b0, 4'h0, na, nvo, npg}, ev.pop_front());
      end
   end
   initial begin
      #200_000;
      fails++;
      summarize();
   end
   initial begin
      void'($urandom(56090));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      nrd <= 16'($urandom);
      chk(3'h0, 8'hE1);
      chk(3'h1, 8'h99);
      chk(3'h2, 8'hFD);
      chk(3'h3, 8'h80);
      chk(3'h5, 8'h01);
      $display("reset test done");
      prog <= 1'b1;
      oe_n <= 1'b0;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_RD_SIG);
      for (int i = 0; i < 8; i++) begin
         ld(pfp_pkg::ACT_ADDR, 1'b0, {6'h00, i[1:0]});
         ld(2'h3, i[2], 8'h00);
         chk(3'h6, SC[63-8*i -: 8]);
      end
      $display("identification test done");
      v = 8'($urandom);
      oe_n <= 1'b1;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_WR_FUSE);
      ld(pfp_pkg::ACT_DATA, 1'b0, v);
      chk(3'h6, 8'hxx);
      wr(8'h00);
      oe_n <= 1'b0;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_RD_FUSE);
      chk(3'h6, v);
      chk(3'h0, 8'hE1);
      oe_n <= 1'b1;
      ser <= 1'b1;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_WR_FUSE);
      ld(pfp_pkg::ACT_DATA, 1'b0, 8'hB1);
      ld(2'h3, 1'b1, 8'h00);
      wr(8'h00);
      chk(3'h7, 8'h00);
      chk(3'h1, 8'h99);
      oe_n <= 1'b0;
      bs2 <= 1'b1;
      ld(pfp_pkg::ACT_CMD, 1'b1, pfp_pkg::CMD_RD_FUSE);
      chk(3'h6, 8'hB1);
      ser <= 1'b0;
      repeat (4) @(posedge clk);
      chk(3'h6, 8'h91);
      bs2 <= 1'b0;
      oe_n <= 1'b1;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_ERASE);
      ev.push_back({1'b0, 4'h0, 16'h0003, pfp_pkg::NVM_ERASE, 9'h000});
      wr(8'h00);
      oe_n <= 1'b0;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_RD_FUSE);
      chk(3'h6, v);
      chk(3'h4, 8'hFF);
      $display("fuse test done");
      oe_n <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         a = 16'($urandom);
         d = 16'($urandom);
         ld(pfp_pkg::ACT_CMD, 1'b0, k ? pfp_pkg::CMD_WR_EE : pfp_pkg::CMD_WR_FLASH);
         ld(pfp_pkg::ACT_ADDR, 1'b1, a[15:8]);
         ld(pfp_pkg::ACT_ADDR, 1'b0, a[7:0]);
         ld(pfp_pkg::ACT_DATA, 1'b1, d[15:8]);
         ld(pfp_pkg::ACT_DATA, 1'b0, d[7:0]);
         ev.push_back(k ? {1'b1, 8'h00, 4'h0, a[2:0], 8'hFF, d[7:0]}
                        : {1'b1, 8'h00, a[6:0], d});
         pgl();
         ev.push_back({1'b0, 4'h0, a, k ? pfp_pkg::NVM_EE : pfp_pkg::NVM_FLASH,
                       k ? a[11:3] : a[15:7]});
         wr(8'h00);
      end
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_NOP);
      pgl();
      wr(8'h01);
      ld(pfp_pkg::ACT_CMD, 1'b0, 8'h55);
      wr(8'h01);
      $display("page test done");
      oe_n <= 1'b0;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_RD_FLASH);
      chk(3'h6, nrd[7:0]);
      ld(2'h3, 1'b1, 8'h00);
      chk(3'h6, nrd[15:8]);
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_RD_EE);
      chk(3'h6, nrd[7:0]);
      $display("read test done");
      oe_n <= 1'b1;
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_WR_LOCK);
      ld(pfp_pkg::ACT_DATA, 1'b0, 8'hFE);
      wr(8'h00);
      chk(3'h4, 8'hFE);
      ld(pfp_pkg::ACT_CMD, 1'b0, pfp_pkg::CMD_WR_FUSE);
      ld(pfp_pkg::ACT_DATA, 1'b0, ~v);
      wr(8'h01);
      prog <= 1'b0;
      repeat (6) @(posedge clk);
      chk(3'h0, v);
      chk(3'h1, 8'h91);
      chk(3'h7, 8'h00);
      $display("lock test done");
      summarize();
   end
endmodule : pfp_port_tb_top
`default_nettype wire

/* test/pfp_prog_model.sv */
// programmer model driving strobe, action, byte select and data
`timescale 1ns/1ps
`default_nettype none
module pfp_prog_model (
   output logic       o_xtal, // crystal strobe
   output logic [1:0] o_act,  // action select hi, lo
   output logic       o_bs1,  // first byte select
   output logic [7:0] o_data  // bus toward the port
);
   initial begin
      o_xtal = 1'b0;
      o_act = 2'h0;
      o_bs1 = 1'b0;
      o_data = 8'h00;
   end
   task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
      o_act = a;
      o_bs1 = b;
      o_data = d;
      #100 o_xtal = 1'b1;
      #24 o_xtal = 1'b0;
      #300 o_act = 2'h3;
      o_data = ~d;
   endtask : load
endmodule : pfp_prog_model
`default_nettype wire
